// file: sbk_pkg.sv
/*
  Shared constants and types for the serial port with Break generation,
  Break and wake-up detection and synchronous master transmission.
  Assumes a single 100 MHz clock and an AXI4-Lite register bus.
*/
package sbk_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam int SBK_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0C;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [15:0] BAUD_RST = 16'h0363;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************
  // Frame shapes
  // ********************************************************
  localparam logic [3:0] BITS_ASYNC = 4'hA;
  localparam logic [3:0] BITS_BREAK = 4'hE;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;

  // Control register, port_enable is bit 0.
  typedef struct packed {
    logic auto_baud_arm;
    logic wake_up_enable;
    logic clock_polarity;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic break_request;
    logic transmit_enable;
    logic clock_source_master;
    logic sync_mode;
    logic port_enable;
  } sbk_ctrl_s;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} sbk_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } sbk_rx_e;

endpackage

// file: sbk_serial_port.sv
/*
  Serial port: asynchronous transmit with Break, asynchronous receive with
  Break and wake-up detection, and synchronous master transmission.
  Assumes an AXI4-Lite master on aclk and that the data pin input comes
  from outside the clock domain.
*/
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sbk_serial_port
  import sbk_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SBK_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SBK_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic receive_data_pin_in,
  output logic receive_data_pin_out,
  output logic receive_data_pin_oe_n,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_n
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    sbk_ctrl_s ctrl;
    logic [BAUD_W-1:0] baud;
    logic [7:0] tdr;
    logic tdr_full;
    logic tdr_brk;
    sbk_tx_e tx;
    logic [13:0] transmit_shift_reg;
    logic [3:0] tcnt;
    logic half;
    logic cur_brk;
    logic [BAUD_W-1:0] bcnt;
    sbk_rx_e rx;
    logic [2:0] rs;
    logic [BAUD_W-1:0] rxc;
    logic [2:0] rbit;
    logic [7:0] rsr;
    logic [7:0] rdr;
    logic rcv;
    logic framing_error_flag;
    logic ck;
    logic ck_oe_n;
    logic dt;
    logic dt_oe_n;
    logic aw_got;
    logic w_got;
    logic [SBK_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sbk_state_s;

  sbk_state_s st_reg;
  sbk_state_s st_next;

  if (BAUD_W < 2 || BAUD_W > 16) begin : g_chk
    $error("BAUD_W must lie between 2 and 16");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic tick;
    logic wr_do;
    logic tx_ok;
    logic sync_tx;
    logic rx_fall;
    logic rx_rise;
    logic rx_line;
    logic [15:0] cv;
    st_next = st_reg;
    tick = 1'b0;
    wr_do = 1'b0;
    cv = '0;
    st_next.rs = {st_reg.rs[1:0], receive_data_pin_in};
    rx_line = st_reg.rs[1];
    rx_fall = st_reg.rs[2] && !st_reg.rs[1];
    rx_rise = !st_reg.rs[2] && st_reg.rs[1];
    sync_tx = st_reg.ctrl.sync_mode && st_reg.ctrl.clock_source_master
      && !st_reg.ctrl.single_receive_enable
      && !st_reg.ctrl.continuous_receive_enable;
    tx_ok = st_reg.ctrl.port_enable && st_reg.ctrl.transmit_enable
      && (!st_reg.ctrl.sync_mode || sync_tx);

    // ********************************************************
    // Register bus
    // ********************************************************
    if (s_axi_awvalid && st_reg.awrdy) begin
      st_next.aw_got = 1'b1;
      st_next.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wrdy) begin
      st_next.w_got = 1'b1;
      st_next.wd = s_axi_wdata;
      st_next.ws = s_axi_wstrb;
    end
    if (st_next.aw_got && st_next.w_got && !st_reg.bvalid) begin
      wr_do = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_next.awa)
        OFS_CTRL: begin
          cv = merge16({6'h00, st_reg.ctrl}, st_next.wd, st_next.ws);
          st_next.ctrl = sbk_ctrl_s'(cv[9:0]);
        end
        OFS_BAUD: begin
          cv = merge16(16'(st_reg.baud), st_next.wd, st_next.ws);
          st_next.baud = cv[BAUD_W-1:0];
        end
        OFS_TXD: begin
          // A write into a full buffer is dropped; software waits for room.
          if (st_next.ws[0] && !st_reg.tdr_full) begin
            st_next.tdr_full = 1'b1;
            st_next.tdr = st_next.wd[7:0];
            // Only the first write after the request becomes the Break,
            // so the byte queued behind it goes out as data.
            st_next.tdr_brk = st_reg.ctrl.break_request
              && !st_reg.ctrl.sync_mode
              && !(st_reg.tx == TX_SHIFT && st_reg.cur_brk);
          end
        end
        OFS_STAT, OFS_RXD: begin
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    if (s_axi_arvalid && st_reg.arrdy) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      unique case (s_axi_araddr)
        OFS_CTRL: st_next.rdata = {22'h000000, st_reg.ctrl};
        OFS_STAT: st_next.rdata = {28'h0000000, st_reg.framing_error_flag, st_reg.rcv,
          !st_reg.tdr_full, st_reg.tx == TX_IDLE};
        OFS_RXD: begin
          st_next.rdata = {24'h000000, st_reg.rdr};
          st_next.rcv = 1'b0;
        end
        OFS_BAUD: st_next.rdata = 32'(st_reg.baud);
        // The shifter and the buffer stay hidden; this offset reads zero.
        OFS_TXD: begin
        end
        default: st_next.rresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // ********************************************************
    // Transmitter
    // ********************************************************
    if (st_reg.tx == TX_SHIFT) begin
      if (st_reg.bcnt == '0) begin
        tick = 1'b1;
        st_next.bcnt = st_reg.baud;
      end else begin
        st_next.bcnt = st_reg.bcnt - 1'b1;
      end
    end
    if (tick) begin
      st_next.half = st_reg.ctrl.sync_mode && !st_reg.half;
      if (st_reg.ctrl.sync_mode && st_reg.half) begin
        st_next.ck = st_reg.ctrl.clock_polarity;
      end else if (st_reg.tcnt == '0) begin
        st_next.tx = TX_IDLE;
        st_next.half = 1'b0;
        if (st_reg.cur_brk) begin
          st_next.ctrl.break_request = 1'b0;
        end
      end else begin
        // Data and the leading clock edge move together.
        st_next.dt = st_reg.transmit_shift_reg[0];
        st_next.ck = st_reg.ctrl.sync_mode ? !st_reg.ctrl.clock_polarity
          : st_reg.transmit_shift_reg[0];
        st_next.transmit_shift_reg = {1'b1, st_reg.transmit_shift_reg[13:1]};
        st_next.tcnt = st_reg.tcnt - 1'b1;
      end
    end
    if (st_next.tx == TX_IDLE && st_next.tdr_full && tx_ok) begin
      st_next.tx = TX_SHIFT;
      st_next.tdr_full = 1'b0;
      st_next.cur_brk = st_next.tdr_brk;
      st_next.bcnt = st_reg.baud;
      st_next.half = 1'b0;
      if (st_reg.ctrl.sync_mode) begin
        st_next.transmit_shift_reg = {6'h3F, st_next.tdr};
        st_next.tcnt = BITS_SYNC;
      end else if (st_next.tdr_brk) begin
        st_next.transmit_shift_reg = 14'h2000;
        st_next.tcnt = BITS_BREAK;
      end else begin
        st_next.transmit_shift_reg = {5'h1F, st_next.tdr, 1'b0};
        st_next.tcnt = BITS_ASYNC;
      end
    end
    if (st_next.tx == TX_IDLE) begin
      st_next.ck = st_reg.ctrl.sync_mode ? st_reg.ctrl.clock_polarity : 1'b1;
      st_next.dt = 1'b1;
    end
    st_next.ck_oe_n = !(st_reg.ctrl.port_enable && (!st_reg.ctrl.sync_mode
      || st_reg.ctrl.clock_source_master));
    st_next.dt_oe_n = !(st_reg.ctrl.port_enable && sync_tx);

    // ********************************************************
    // Receiver
    // ********************************************************
    if (st_reg.ctrl.wake_up_enable) begin
      st_next.rx = RX_IDLE;
      if (rx_fall) begin
        st_next.rcv = 1'b1;
      end
      if (rx_rise) begin
        st_next.ctrl.wake_up_enable = 1'b0;
      end
    end else if (!st_reg.ctrl.port_enable || st_reg.ctrl.sync_mode
                 || !st_reg.ctrl.continuous_receive_enable) begin
      st_next.rx = RX_IDLE;
    end else begin
      st_next.rxc = st_reg.rxc - 1'b1;
      unique case (st_reg.rx)
        RX_IDLE: begin
          if (rx_fall) begin
            st_next.rx = RX_START;
            st_next.rxc = st_reg.baud >> 1;
          end
        end
        RX_START: begin
          if (st_reg.rxc == '0) begin
            st_next.rxc = st_reg.baud;
            st_next.rbit = '0;
            st_next.rx = rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (st_reg.rxc == '0) begin
            st_next.rxc = st_reg.baud;
            st_next.rsr = {rx_line, st_reg.rsr[7:1]};
            st_next.rbit = st_reg.rbit + 1'b1;
            if (st_reg.rbit == RX_LAST_BIT) begin
              st_next.rx = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (st_reg.rxc == '0) begin
            // A Break lands here as 00h with a low stop bit.
            st_next.rx = RX_IDLE;
            st_next.rdr = st_reg.rsr;
            st_next.framing_error_flag = !rx_line;
            st_next.rcv = 1'b1;
          end
        end
      endcase
    end

    // Clearing the port enable acts as a reset of both shifters.
    if (!st_reg.ctrl.port_enable && !wr_do) begin
      st_next.tx = TX_IDLE;
      st_next.tdr_full = 1'b0;
    end

    st_next.awrdy = !st_next.aw_got && !st_next.bvalid;
    st_next.wrdy = !st_next.w_got && !st_next.bvalid;
    st_next.arrdy = !st_next.rvalid;

    if (!aresetn) begin
      st_next = '0;
      st_next.baud = BAUD_RST[BAUD_W-1:0];
      st_next.rs = 3'h7;
      st_next.ck = 1'b1;
      st_next.dt = 1'b1;
      st_next.ck_oe_n = 1'b1;
      st_next.dt_oe_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign s_axi_awready = st_reg.awrdy;
  assign s_axi_wready = st_reg.wrdy;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arrdy;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  // Async mode frames leave on the clock pin; sync data on the data pin.
  assign transmit_clock_pin_out = st_reg.ck;
  assign transmit_clock_pin_oe_n = st_reg.ck_oe_n;
  assign receive_data_pin_out = st_reg.dt;
  assign receive_data_pin_oe_n = st_reg.dt_oe_n;

endmodule

// file: sbk_serial_port_asserts.sv
/*
  Checker for the serial port's bus handshake and pin drivers.
  Bound to the serial port top module and sees only its ports.
*/
`timescale 1ns/1ps
module sbk_serial_port_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic receive_data_pin_out,
  input wire logic receive_data_pin_oe_n,
  input wire logic transmit_clock_pin_out,
  input wire logic transmit_clock_pin_oe_n
);
  // ****
  // Properties
  // ****
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  AST_AW_BLOCKED: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready early");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready early");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_RESET_PINS: assert property ($rose(aresetn) |->
    transmit_clock_pin_oe_n && receive_data_pin_oe_n &&
    transmit_clock_pin_out && receive_data_pin_out)
    else $error("pins not idle after reset");
  AST_DT_OE: assert property (
    !receive_data_pin_oe_n |-> !transmit_clock_pin_oe_n)
    else $error("data driven without clock driver");
endmodule

// file: sbk_lin_node.sv
/*
  Far-side model: a bus node driving the receive line with a 160 ns bit
  time, and a synchronous slave shifting in on the trailing clock edge.
  Assumes the bench resolves the shared data wire.
*/
`timescale 1ns/1ps
module sbk_lin_node (
  input wire logic transmit_clock_pin_out,
  input wire logic transmit_clock_pin_oe_n,
  input wire logic receive_data_pin_in,
  input wire logic receive_data_pin_oe_n,
  input wire logic pol,
  output logic line_out
);
  logic [7:0] cap = 8'h0;
  int clk_cnt = 0;
  initial line_out = 1'h1;
  // ****
  // Slave shift on the return to the idle level
  // ****
  always @(transmit_clock_pin_out) begin
    if (!transmit_clock_pin_oe_n && !receive_data_pin_oe_n &&
        transmit_clock_pin_out === pol) begin
      cap = {receive_data_pin_in, cap[7:1]};
      clk_cnt++;
    end
  end
  // Off the clock edge so the port's synchroniser sees a clean change.
  task automatic send(input logic [15:0] bits, input int n);
    #3;
    for (int i = 0; i < n; i++) begin
      line_out = bits[i];
      #160;
    end
    line_out = 1'h1;
  endtask
endmodule

// file: sbk_serial_port_test.sv
/*
  Self-checking bench for the serial port: bus, Break, receive, wake-up
  and synchronous master. Assumes the far-side model and the checker.
*/
`timescale 1ns/1ps
module sbk_serial_port_test
  import sbk_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, pol = 1'h0;
  logic [SBK_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, line_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic receive_data_pin_out, receive_data_pin_oe_n;
  logic transmit_clock_pin_out, transmit_clock_pin_oe_n;
  int errors = 0, check_count = 0;
  wire receive_data_pin_in = receive_data_pin_oe_n ? line_out :
    receive_data_pin_out;
  always #5 aclk = ~aclk;
  sbk_serial_port dut_u (.*);
  sbk_lin_node p_u (.*);
  // ****
  // Bus and compare tasks
  // ****
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      errors++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
      n++;
    end while (!(s_axi_bvalid === 1'h1 && s_axi_bready) && n < 200);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
      n++;
    end while (!(s_axi_rvalid === 1'h1 && s_axi_rready) && n < 200);
    rd_val = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    tmo(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(rd_val, e);
  endtask
  task automatic wait_stat(input logic [3:0] m, input logic [3:0] v);
    int n;
    n = 0;
    do begin
      rd(OFS_STAT);
      n++;
    end while ((rd_val[3:0] & m) !== v && n < 200);
    tmo(n);
  endtask
  // Samples mid-bit, sixteen cycles to a bit with the divisor at 15.
  task automatic get_frame(input int nb, output logic [15:0] b);
    int n;
    n = 0;
    b = '0;
    while (transmit_clock_pin_out !== 1'h0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      b[i] = transmit_clock_pin_out;
      if (i < nb - 1) repeat (16) @(posedge aclk);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rdc(OFS_BAUD, 32'h363);
    cmp(32'(rsp), 32'(RESP_OKAY));
    rdc(OFS_STAT, 32'h3);
    rdc(OFS_TXD, 32'h0);
    rd(8'h20);
    cmp(32'(rsp), 32'(RESP_SLVERR));
    wr(8'h20, 32'h0);
    cmp(32'(wrsp), 32'(RESP_SLVERR));
    wr(OFS_BAUD, 32'hF);
    cmp(32'(wrsp), 32'(RESP_OKAY));
    rdc(OFS_BAUD, 32'hF);
  endtask
  task automatic t_break;
    logic [15:0] b;
    wr(OFS_CTRL, 32'h19);
    wr(OFS_TXD, 32'hA5);
    wait_stat(4'h2, 4'h2);
    wr(OFS_TXD, 32'h55);
    rdc(OFS_STAT, 32'h0);
    get_frame(14, b);
    cmp(32'(b), 32'h2000);
    get_frame(10, b);
    cmp(32'(b), 32'h2AA);
    rdc(OFS_CTRL, 32'h9);
    wait_stat(4'h1, 4'h1);
  endtask
  task automatic t_rx_break;
    wr(OFS_CTRL, 32'h41);
    p_u.send(16'h2000, 14);
    wait_stat(4'h4, 4'h4);
    rdc(OFS_STAT, 32'hF);
    rdc(OFS_RXD, 32'h0);
    rd(OFS_STAT);
    cmp(32'(rd_val[2]), 32'h0);
  endtask
  task automatic t_wake;
    wr(OFS_CTRL, 32'h341);
    p_u.send(16'h2000, 14);
    wait_stat(4'h4, 4'h4);
    rdc(OFS_CTRL, 32'h241);
    rd(OFS_RXD);
    rd(OFS_STAT);
    cmp(32'(rd_val[2]), 32'h0);
    p_u.send(16'h386, 10);
    wait_stat(4'h4, 4'h4);
    rdc(OFS_RXD, 32'hC3);
  endtask
  task automatic t_sync(input logic p);
    pol <= p;
    wr(OFS_CTRL, p ? 32'h8F : 32'hF);
    repeat (2) @(posedge aclk);
    cmp(32'(transmit_clock_pin_out), 32'(p));
    cmp(32'({transmit_clock_pin_oe_n, receive_data_pin_oe_n}), 32'h0);
    p_u.clk_cnt = 0;
    wr(OFS_TXD, 32'h96);
    wait_stat(4'h1, 4'h1);
    cmp(32'(p_u.cap), 32'h96);
    cmp(32'(p_u.clk_cnt), 32'h8);
    cmp(32'(transmit_clock_pin_out), 32'(p));
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_break;
    t_rx_break;
    t_wake;
    t_sync(1'h0);
    t_sync(1'h1);
    end_of_test;
  end
endmodule
bind sbk_serial_port sbk_serial_port_asserts chk_u (.*);
